// ---- rtl/ttc_pkg.sv ----
// constants, states and signal groups for the tape transport operator control
package ttc_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned VAC_DELAY_MS  = 2000;
  localparam int unsigned SEEK_FWD_MS   = 5000;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned VAC_DELAY_CYC = VAC_DELAY_MS * CYC_PER_MS;
  localparam int unsigned SEEK_FWD_CYC  = SEEK_FWD_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned TIMER_W       = 32;

  // ------------------------------------------------------------------
  // panel keys and unit address
  // ------------------------------------------------------------------
  localparam int unsigned NUM_KEYS   = 3;
  localparam int unsigned KEY_LOAD   = 0;
  localparam int unsigned KEY_ONLINE = 1;
  localparam int unsigned KEY_REWIND = 2;
  localparam int unsigned ADDR_W     = 3;

  // ------------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [8:0] {
    S_UNLOADED = 9'h001,
    S_VAC_WAIT = 9'h002,
    S_PULL     = 9'h004,
    S_SEEK_FWD = 9'h008,
    S_SEEK_REW = 9'h010,
    S_OFFLINE  = 9'h020,
    S_ONLINE   = 9'h040,
    S_REWIND   = 9'h080,
    S_UNLOAD   = 9'h100
  } ttc_state_t;

  // ------------------------------------------------------------------
  // signal groups
  // ------------------------------------------------------------------
  typedef struct packed {
    logic rewind;
    logic online;
    logic load;
  } ttc_keys_t;

  typedef struct packed {
    logic              present;
    logic [ADDR_W-1:0] addr;
  } ttc_addr_t;

  typedef struct packed {
    logic threaded;
    logic columns_ok;
    logic tape_start_marker;
    logic reel_present;
    logic write_ring;
    logic unload_done;
    logic power_ok;
    logic fail_safe;
  } ttc_mech_t;

  typedef struct packed {
    logic direction_switch;
    logic run_switch;
  } ttc_maint_t;

  typedef struct packed {
    logic load;
    logic online;
    logic tape_start_marker;
    logic write_lock_lamp;
    logic select;
  } ttc_lamps_t;

  typedef struct packed {
    logic vacuum_on;
    logic run;
    logic reverse;
    logic high_speed;
    logic unload_wind;
  } ttc_motion_t;

endpackage

// ---- rtl/ttc_operator_control.sv ----
// operator panel sequencer of a magnetic tape transport
`timescale 1ns/1ns
module ttc_operator_control #(
  parameter int unsigned VAC_DELAY_CYC = ttc_pkg::VAC_DELAY_CYC,
  parameter int unsigned SEEK_FWD_CYC  = ttc_pkg::SEEK_FWD_CYC,
  parameter int unsigned DEBOUNCE_CYC  = ttc_pkg::DEBOUNCE_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ce_i,
  input  wire ttc_pkg::ttc_keys_t          keys_i,
  input  wire ttc_pkg::ttc_mech_t          mech_i,
  input  wire ttc_pkg::ttc_maint_t         maint_i,
  input  wire ttc_pkg::ttc_addr_t          plug_i,
  input  wire ttc_pkg::ttc_addr_t          sel_i,
  output ttc_pkg::ttc_lamps_t              lamps_o,
  output ttc_pkg::ttc_motion_t             motion_o,
  output logic                             unit_selected_o,
  output logic [ttc_pkg::ADDR_W-1:0]       unit_addr_o
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  localparam logic [ttc_pkg::TIMER_W-1:0] VAC_LOAD  = ttc_pkg::TIMER_W'(VAC_DELAY_CYC - 1);
  localparam logic [ttc_pkg::TIMER_W-1:0] SEEK_LOAD = ttc_pkg::TIMER_W'(SEEK_FWD_CYC - 1);
  localparam logic [ttc_pkg::TIMER_W-1:0] DB_LAST   = ttc_pkg::TIMER_W'(DEBOUNCE_CYC - 1);

  ttc_pkg::ttc_state_t          state_reg;
  ttc_pkg::ttc_state_t          state_next;
  logic [ttc_pkg::TIMER_W-1:0]  timer_reg;
  logic                         target_online_reg;
  logic                         target_online_next;
  logic                         maint_run_reg;
  logic                         maint_run_next;
  logic                         run_prev_reg;
  logic [ttc_pkg::NUM_KEYS-1:0] key_raw;
  logic [ttc_pkg::NUM_KEYS-1:0] press_reg;
  logic                         shutdown;
  logic                         load_lamp;
  logic                         loading;
  logic                         selected;
  ttc_pkg::ttc_motion_t         motion_next;

  assign key_raw   = keys_i;
  assign shutdown  = !mech_i.power_ok || mech_i.fail_safe;
  // load lamp needs the columns and stays off in the unloaded and delay states
  assign load_lamp = mech_i.columns_ok && !(state_reg inside
                     {ttc_pkg::S_UNLOADED, ttc_pkg::S_VAC_WAIT});
  assign loading   = state_reg inside {ttc_pkg::S_VAC_WAIT, ttc_pkg::S_PULL,
                                       ttc_pkg::S_SEEK_FWD, ttc_pkg::S_SEEK_REW};
  // no plug never matches, whatever the controller asks for
  assign selected  = plug_i.present && sel_i.present
                     && (sel_i.addr == plug_i.addr);

  // ------------------------------------------------------------------
  // key debounce
  // ------------------------------------------------------------------
  // a key must hold its new level for the whole window before it counts;
  // chatter restarts the window, so a bouncing press gives one event
  for (genvar k = 0; k < ttc_pkg::NUM_KEYS; k++) begin : g_key
    logic [ttc_pkg::TIMER_W-1:0] db_cnt_reg;
    logic                        stable_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        db_cnt_reg   <= '0;
        stable_reg   <= 1'b0;
        press_reg[k] <= 1'b0;
      end else if (ce_i) begin
        press_reg[k] <= 1'b0;
        if (key_raw[k] != stable_reg) begin
          if (db_cnt_reg == DB_LAST) begin
            db_cnt_reg   <= '0;
            stable_reg   <= key_raw[k];
            press_reg[k] <= key_raw[k];
          end else begin
            db_cnt_reg <= db_cnt_reg + 1'b1;
          end
        end else begin
          db_cnt_reg <= '0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next         = state_reg;
    target_online_next = target_online_reg;
    unique case (state_reg)
      ttc_pkg::S_UNLOADED: begin
        if (press_reg[ttc_pkg::KEY_LOAD] && mech_i.threaded) begin
          state_next         = ttc_pkg::S_VAC_WAIT;
          target_online_next = 1'b1;
        end
      end
      ttc_pkg::S_VAC_WAIT: begin
        if (timer_reg == '0) begin
          state_next = ttc_pkg::S_PULL;
        end
      end
      ttc_pkg::S_PULL: begin
        if (mech_i.columns_ok) begin
          state_next = ttc_pkg::S_SEEK_FWD;
        end
      end
      ttc_pkg::S_SEEK_FWD: begin
        if (press_reg[ttc_pkg::KEY_REWIND]) begin
          state_next = ttc_pkg::S_REWIND;
        end else if (timer_reg == '0) begin
          state_next = ttc_pkg::S_SEEK_REW;
        end
      end
      ttc_pkg::S_SEEK_REW: begin
        if (mech_i.tape_start_marker) begin
          state_next = target_online_reg ? ttc_pkg::S_ONLINE : ttc_pkg::S_OFFLINE;
        end
      end
      ttc_pkg::S_OFFLINE: begin
        if (press_reg[ttc_pkg::KEY_ONLINE] && load_lamp) begin
          state_next = ttc_pkg::S_ONLINE;
        end else if (press_reg[ttc_pkg::KEY_REWIND]) begin
          state_next = mech_i.tape_start_marker ? ttc_pkg::S_UNLOAD
                                                : ttc_pkg::S_REWIND;
        end
      end
      ttc_pkg::S_ONLINE: begin
        // rewind key has no path out of here
        if (press_reg[ttc_pkg::KEY_ONLINE] && load_lamp) begin
          state_next = ttc_pkg::S_OFFLINE;
        end
      end
      ttc_pkg::S_REWIND: begin
        if (mech_i.tape_start_marker) begin
          state_next = ttc_pkg::S_OFFLINE;
        end
      end
      ttc_pkg::S_UNLOAD: begin
        if (mech_i.unload_done) begin
          state_next = ttc_pkg::S_UNLOADED;
        end
      end
      default: begin
        state_next = ttc_pkg::S_UNLOADED;
      end
    endcase
    // during a load the key only decides where the load ends up
    if (loading && press_reg[ttc_pkg::KEY_ONLINE]) begin
      target_online_next = !target_online_reg;
    end
    // shutdown drops to unloaded: off-line, and only a load leaves it
    if (shutdown) begin
      state_next = ttc_pkg::S_UNLOADED;
    end
  end

  // ------------------------------------------------------------------
  // maintenance run/halt
  // ------------------------------------------------------------------
  always_comb begin
    maint_run_next = maint_run_reg;
    if (state_next != ttc_pkg::S_OFFLINE) begin
      maint_run_next = 1'b0;
    end else if (maint_i.run_switch && !run_prev_reg) begin
      maint_run_next = 1'b1;
    end else if (!maint_i.run_switch && run_prev_reg) begin
      maint_run_next = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // motion commands
  // ------------------------------------------------------------------
  always_comb begin
    motion_next           = '0;
    motion_next.vacuum_on = !(state_next inside {ttc_pkg::S_UNLOADED});
    unique case (state_next)
      ttc_pkg::S_SEEK_FWD: begin
        motion_next.run = 1'b1;
      end
      ttc_pkg::S_SEEK_REW, ttc_pkg::S_REWIND: begin
        motion_next.run        = 1'b1;
        motion_next.reverse    = 1'b1;
        motion_next.high_speed = 1'b1;
      end
      ttc_pkg::S_UNLOAD: begin
        motion_next.run         = 1'b1;
        motion_next.reverse     = 1'b1;
        motion_next.unload_wind = 1'b1;
      end
      ttc_pkg::S_OFFLINE: begin
        // direction alone never sets run
        motion_next.run     = maint_run_next;
        motion_next.reverse = maint_i.direction_switch;
      end
      default: begin
        motion_next.run = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg         <= ttc_pkg::S_UNLOADED;
      target_online_reg <= 1'b1;
    end else if (ce_i) begin
      state_reg         <= state_next;
      target_online_reg <= target_online_next;
    end
  end

  // one timer serves both timed phases; it reloads on entry
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_reg <= '0;
    end else if (ce_i) begin
      if (state_next != state_reg && state_next == ttc_pkg::S_VAC_WAIT) begin
        timer_reg <= VAC_LOAD;
      end else if (state_next != state_reg && state_next == ttc_pkg::S_SEEK_FWD) begin
        timer_reg <= SEEK_LOAD;
      end else if (timer_reg != '0) begin
        timer_reg <= timer_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      maint_run_reg <= 1'b0;
      run_prev_reg  <= 1'b0;
    end else if (ce_i) begin
      maint_run_reg <= maint_run_next;
      run_prev_reg  <= maint_i.run_switch;
    end
  end

  // ------------------------------------------------------------------
  // lamps and outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lamps_o         <= '0;
      motion_o        <= '0;
      unit_selected_o <= 1'b0;
      unit_addr_o     <= '0;
    end else if (ce_i) begin
      motion_o                  <= motion_next;
      lamps_o.load              <= mech_i.columns_ok && motion_next.vacuum_on
                                   && state_next != ttc_pkg::S_VAC_WAIT;
      lamps_o.online            <= state_next == ttc_pkg::S_ONLINE;
      lamps_o.tape_start_marker <= mech_i.tape_start_marker;
      lamps_o.write_lock_lamp   <= !mech_i.reel_present || !mech_i.write_ring;
      lamps_o.select            <= state_next == ttc_pkg::S_ONLINE && selected;
      unit_selected_o           <= state_next == ttc_pkg::S_ONLINE && selected;
      unit_addr_o               <= plug_i.addr;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_online_lamp;
    lamps_o.online == (state_reg == ttc_pkg::S_ONLINE);
  endproperty
  a_online_lamp: assert property (p_online_lamp)
    else $error("on-line lamp disagrees with state");

  property p_rewind_ignored_online;
    (ce_i && state_reg == ttc_pkg::S_ONLINE && press_reg[ttc_pkg::KEY_REWIND]
     && !press_reg[ttc_pkg::KEY_ONLINE] && !shutdown) |=> state_reg == ttc_pkg::S_ONLINE;
  endproperty
  a_rewind_ignored_online: assert property (p_rewind_ignored_online)
    else $error("rewind key acted while on-line");

  property p_online_needs_load;
    (ce_i && state_reg == ttc_pkg::S_UNLOADED) |=> state_reg != ttc_pkg::S_ONLINE;
  endproperty
  a_online_needs_load: assert property (p_online_needs_load)
    else $error("on-line reached without a load");

  property p_power_stop;
    (ce_i && !mech_i.power_ok) |=> (motion_o == '0 && !lamps_o.online);
  endproperty
  a_power_stop: assert property (p_power_stop)
    else $error("motion continues after power loss");

  property p_fail_safe;
    (ce_i && mech_i.fail_safe) |=> (!motion_o.vacuum_on && !motion_o.run);
  endproperty
  a_fail_safe: assert property (p_fail_safe)
    else $error("vacuum or motion kept after fail-safe");

  property p_select;
    lamps_o.select |-> (lamps_o.online && $past(plug_i.present));
  endproperty
  a_select: assert property (p_select)
    else $error("select lamp lit while not on-line or unplugged");

  property p_status_lamps;
    ce_i |=> (lamps_o.tape_start_marker == $past(mech_i.tape_start_marker)
              && lamps_o.write_lock_lamp == $past(!mech_i.reel_present || !mech_i.write_ring));
  endproperty
  a_status_lamps: assert property (p_status_lamps)
    else $error("marker or write lock lamp wrong");

  property p_seek_turn;
    (ce_i && state_reg == ttc_pkg::S_SEEK_FWD && timer_reg == '0
     && !press_reg[ttc_pkg::KEY_REWIND] && !shutdown) |=> state_reg == ttc_pkg::S_SEEK_REW;
  endproperty
  a_seek_turn: assert property (p_seek_turn)
    else $error("forward seek did not turn to rewind");

  property p_seek_abort;
    (ce_i && state_reg == ttc_pkg::S_SEEK_FWD && press_reg[ttc_pkg::KEY_REWIND]
     && !shutdown) |=> (state_reg == ttc_pkg::S_REWIND ##1 motion_o.high_speed || !ce_i);
  endproperty
  a_seek_abort: assert property (p_seek_abort)
    else $error("rewind key did not abort the load");

  property p_direction_no_start;
    (ce_i && state_reg == ttc_pkg::S_OFFLINE && !maint_run_reg
     && maint_i.run_switch == run_prev_reg) |=> !maint_run_reg;
  endproperty
  a_direction_no_start: assert property (p_direction_no_start)
    else $error("motion started without a run edge");

endmodule

// ---- verification/ttc_mech_model.sv ----
// behavioural model of the tape mechanics: columns, marker position, unload wind
`timescale 1ns/1ns
module ttc_mech_model (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire ttc_pkg::ttc_motion_t motion_i,
  input  wire ttc_pkg::ttc_mech_t   ctl_i,
  output ttc_pkg::ttc_mech_t        mech_o
);
  logic [7:0] pos_reg;
  logic [2:0] vac_reg;
  logic [2:0] wind_reg;

  // columns fill well before the vacuum delay ends, so the delay is the block's own
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vac_reg <= 3'h0;
    end else if (!motion_i.vacuum_on) begin
      vac_reg <= 3'h0;
    end else if (vac_reg != 3'h3) begin
      vac_reg <= vac_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_reg <= 8'h00;
    end else if (motion_i.run && !motion_i.reverse) begin
      pos_reg <= pos_reg + 8'h01;
    end else if (motion_i.run && pos_reg != 8'h00) begin
      pos_reg <= pos_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wind_reg <= 3'h0;
    end else if (!motion_i.unload_wind) begin
      wind_reg <= 3'h0;
    end else if (wind_reg != 3'h5) begin
      wind_reg <= wind_reg + 3'h1;
    end
  end

  always_comb begin
    mech_o                   = ctl_i;
    mech_o.columns_ok        = (vac_reg == 3'h3);
    mech_o.tape_start_marker = (pos_reg == 8'h00);
    mech_o.unload_done       = (wind_reg == 3'h5);
  end
endmodule

// ---- verification/ttc_operator_control_tb_top.sv ----
// self-checking bench for the tape transport operator control
`timescale 1ns/1ns
module ttc_operator_control_tb_top;
  localparam int VAC    = 20;
  localparam int SEEK   = 30;
  localparam int DEB    = 4;
  localparam int O_LOAD = 9;
  localparam int O_ONL  = 8;
  localparam int O_WRL  = 6;
  localparam int O_SEL  = 5;
  localparam int O_VAC  = 4;
  localparam int O_RUN  = 3;
  localparam int O_REV  = 2;
  localparam int O_HS   = 1;
  localparam int O_UNW  = 0;
  logic                 clk_i;
  logic                 rst_n_i;
  ttc_pkg::ttc_keys_t   keys;
  ttc_pkg::ttc_mech_t   ctl;
  ttc_pkg::ttc_mech_t   mech;
  ttc_pkg::ttc_maint_t  maint;
  ttc_pkg::ttc_addr_t   plug;
  ttc_pkg::ttc_addr_t   sel;
  ttc_pkg::ttc_lamps_t  lamps;
  ttc_pkg::ttc_motion_t motion;
  logic                 unit_sel;
  logic [2:0]           unit_addr;
  logic [9:0]           obs;
  int                   n_fail;
  int                   n_tests;
  int                   cycles;

  assign obs = {lamps, motion};

  ttc_operator_control #(.VAC_DELAY_CYC(VAC), .SEEK_FWD_CYC(SEEK), .DEBOUNCE_CYC(DEB)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .keys_i(keys), .mech_i(mech),
    .maint_i(maint), .plug_i(plug), .sel_i(sel), .lamps_o(lamps), .motion_o(motion),
    .unit_selected_o(unit_sel), .unit_addr_o(unit_addr));

  ttc_mech_model u_mech (.clk_i(clk_i), .rst_n_i(rst_n_i), .motion_i(motion),
    .ctl_i(ctl), .mech_o(mech));

  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hung sequence would otherwise stall the run silently
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chb(input string what, input logic seen, input logic exp);
    chk(what, {9'h000, seen}, {9'h000, exp});
  endtask

  task automatic wait_obs(input int b, input logic v, input int lim, output int n);
    n = 0;
    while (obs[b] !== v && n < lim) begin
      cyc(1);
      n++;
    end
    chb("wait output", obs[b], v);
  endtask

  // a release must also stay stable through a debounce before the next press
  task automatic press(input int k, input int hold);
    keys[k] = 1'b1;
    cyc(hold);
    keys[k] = 1'b0;
    cyc(2 * DEB);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_idle;
    int i;
    press(ttc_pkg::KEY_ONLINE, 2 * DEB);
    chk("idle online key", obs & 10'h11f, 10'h000);
    press(ttc_pkg::KEY_REWIND, 2 * DEB);
    chk("idle rewind key", obs & 10'h11f, 10'h000);
    for (i = 0; i < 4; i++) begin
      ctl.reel_present = i[1];
      ctl.write_ring   = i[0];
      cyc(3);
      chb("write lock lamp", obs[O_WRL], !(i[1] && i[0]));
    end
  endtask

  task automatic t_load;
    int n;
    keys.load = 1'b1;
    wait_obs(O_VAC, 1'b1, 3 * DEB, n);
    keys.load = 1'b0;
    cyc(5);
    chb("load lamp in delay", obs[O_LOAD], 1'b0);
    wait_obs(O_RUN, 1'b1, 2 * VAC, n);
    chb("vacuum delay", n + 5 >= VAC - 1 && n + 5 <= VAC + 3, 1'b1);
    chb("load lamp", obs[O_LOAD], 1'b1);
    chb("seek forward", obs[O_REV], 1'b0);
    wait_obs(O_REV, 1'b1, 2 * SEEK, n);
    chb("seek time", n >= SEEK - 1 && n <= SEEK + 1, 1'b1);
    chb("seek rewind fast", obs[O_HS], 1'b1);
    wait_obs(O_ONL, 1'b1, 3 * SEEK, n);
    cyc(2);
    chk("loaded on-line", obs, 10'h390);
  endtask

  // an on-line press while the load runs makes the load end off-line
  task automatic t_load_offline;
    int n;
    keys.load = 1'b1;
    wait_obs(O_VAC, 1'b1, 3 * DEB, n);
    keys.load = 1'b0;
    press(ttc_pkg::KEY_ONLINE, 2 * DEB);
    wait_obs(O_REV, 1'b1, 2 * VAC + 2 * SEEK, n);
    wait_obs(O_RUN, 1'b0, 3 * SEEK, n);
    cyc(2);
    chk("load ends off-line", obs, 10'h290);
  endtask

  task automatic t_keys;
    repeat (4) begin
      keys.online = 1'b1;
      cyc(DEB - 1);
      keys.online = 1'b0;
      cyc(DEB - 1);
    end
    cyc(2 * DEB);
    chb("chatter ignored", obs[O_ONL], 1'b1);
    press(ttc_pkg::KEY_ONLINE, 6 * DEB);
    chk("long press one toggle", obs, 10'h290);
    press(ttc_pkg::KEY_ONLINE, 2 * DEB);
    chk("toggle back", obs, 10'h390);
  endtask

  task automatic t_select;
    int i;
    for (i = 0; i < 4; i++) begin
      plug.present = (i != 2);
      sel.present  = (i != 3);
      sel.addr     = (i == 1) ? 3'h4 : 3'h5;
      cyc(3);
      chk("select", {8'h00, obs[O_SEL], unit_sel}, (i == 0) ? 10'h003 : 10'h000);
    end
    chk("unit address", {7'h00, unit_addr}, 10'h005);
    plug.present = 1'b1;
    sel.present  = 1'b0;
    sel.addr     = 3'h5;
  endtask

  task automatic t_online_locks;
    press(ttc_pkg::KEY_REWIND, 2 * DEB);
    chk("rewind on-line", obs, 10'h390);
    maint.run_switch = 1'b1;
    cyc(5);
    chk("maint on-line", obs, 10'h390);
    maint.run_switch = 1'b0;
    cyc(3);
    sel.present = 1'b1;
    press(ttc_pkg::KEY_ONLINE, 2 * DEB);
    chk("off-line unselected", obs, 10'h290);
  endtask

  task automatic t_maint;
    maint.direction_switch = 1'b1;
    cyc(4);
    maint.direction_switch = 1'b0;
    cyc(4);
    chk("direction only", obs, 10'h290);
    maint.run_switch = 1'b1;
    cyc(4);
    chk("run forward", obs & 10'h08f, 10'h008);
    cyc(10);
    maint.run_switch = 1'b0;
    cyc(4);
    chk("halt", obs & 10'h00f, 10'h000);
    maint.direction_switch = 1'b1;
    maint.run_switch = 1'b1;
    cyc(4);
    chk("run reverse", obs & 10'h00f, 10'h00c);
    maint.run_switch = 1'b0;
    maint.direction_switch = 1'b0;
    cyc(4);
    chk("halt again", obs & 10'h00f, 10'h000);
    sel.present = 1'b0;
  endtask

  // rewind key held by hand so the fast rewind or unload wind is seen before it ends
  task automatic t_rewind(input int bit_seen, input logic [9:0] exp);
    int n;
    keys.rewind = 1'b1;
    wait_obs(bit_seen, 1'b1, 3 * DEB, n);
    chk("rewind motion", obs & 10'h10f, exp);
    keys.rewind = 1'b0;
    wait_obs(O_RUN, 1'b0, 40, n);
    cyc(2 * DEB);
  endtask

  task automatic t_shut;
    ctl.power_ok = 1'b0;
    cyc(3);
    chk("power loss", obs & 10'h11f, 10'h000);
    ctl.power_ok = 1'b1;
    press(ttc_pkg::KEY_ONLINE, 2 * DEB);
    chk("no on-line after loss", obs & 10'h11f, 10'h000);
    t_load();
    ctl.fail_safe = 1'b1;
    cyc(3);
    chk("fail-safe", obs & 10'h11f, 10'h000);
    press(ttc_pkg::KEY_ONLINE, 2 * DEB);
    ctl.fail_safe = 1'b0;
    press(ttc_pkg::KEY_ONLINE, 2 * DEB);
    press(ttc_pkg::KEY_REWIND, 2 * DEB);
    chk("commands after fail-safe", obs & 10'h11f, 10'h000);
  endtask

  initial begin
    int n;
    n_fail  = 0;
    n_tests = 0;
    cycles  = 0;
    rst_n_i = 1'b0;
    keys    = '0;
    maint   = '0;
    plug    = '{1'b1, 3'h5};
    sel     = '{1'b0, 3'h5};
    ctl     = '0;
    ctl.threaded     = 1'b1;
    ctl.reel_present = 1'b1;
    ctl.write_ring   = 1'b1;
    ctl.power_ok     = 1'b1;
    repeat (12) @(posedge clk_i);
    #2;
    rst_n_i = 1'b1;
    cyc(2);
    t_idle();
    t_load();
    t_keys();
    t_select();
    t_online_locks();
    t_maint();
    t_rewind(O_HS, 10'h00e);
    chk("rewound off-line", obs, 10'h290);
    t_rewind(O_UNW, 10'h00d);
    chk("unloaded", obs & 10'h01f, 10'h000);
    keys.load = 1'b1;
    wait_obs(O_VAC, 1'b1, 3 * DEB, n);
    keys.load = 1'b0;
    wait_obs(O_RUN, 1'b1, 2 * VAC + 10, n);
    t_rewind(O_HS, 10'h00e);
    chk("aborted load off-line", obs, 10'h290);
    t_rewind(O_UNW, 10'h00d);
    t_load_offline();
    t_rewind(O_UNW, 10'h00d);
    t_load();
    t_shut();
    report_and_stop();
  end
endmodule
